// ### design/pdp_regs.svh
/*
 register offsets, field positions, reset values and mode codes for the port direction and pull-up block.
 assumes a byte-addressed avalon-mm slave with 32-bit data.
*/
`ifndef PDP_REGS_SVH
`define PDP_REGS_SVH

// ----------------------------------------------------------------
// offsets (byte addresses)
// ----------------------------------------------------------------
`define PDP_OFS_DIR      4'h0
`define PDP_OFS_PUE      4'h4
`define PDP_OFS_CTRL     4'h8
`define PDP_OFS_STAT     4'hC

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define PDP_PIN3         3
`define PDP_XTAL_LO      4
`define PDP_XTAL_HI      5
`define PDP_CTRL_GPU     0
`define PDP_DIR_RST      6'h3F
`define PDP_PUE_RST      6'h3F
`define PDP_GPU_RST      1'h0

// ----------------------------------------------------------------
// oscillator mode codes
// ----------------------------------------------------------------
`define PDP_OSC_LP       3'h0
`define PDP_OSC_XT       3'h1
`define PDP_OSC_HS       3'h2

`endif

// ### design/pdp_pkg.sv
/*
 types for the port direction and pull-up block.
 assumes pdp_regs.svh supplies the numeric constants.
*/
package pdp_pkg;

   typedef enum logic [1:0] {
      PDP_IDLE,
      PDP_ANSWER
   } pdp_bus_e;

   typedef struct packed {
      logic [5:0] dir;
      logic [5:0] pue;
   } pdp_pins_s;

endpackage : pdp_pkg

// ### design/pdp_pin_cell.sv
/*
 one pin's effective output-enable and weak pull-up.
 assumes all inputs are synchronous to the system clock.
*/
`timescale 1ns/1ps

module pdp_pin_cell (
   // stored control
   input  wire logic dir_bit,
   input  wire logic pue_bit,
   // global conditions
   input  wire logic global_pullup_enable,
   input  wire logic force_input,
   input  wire logic force_pullup,
   // effective pin control
   output logic      out_en,
   output logic      pullup_on
);

   logic is_input;

   assign is_input = dir_bit | force_input;
   assign out_en   = ~is_input;

   // global, individual and input direction, or master clear
   // output direction kills the individual pull-up, which global gates; force_pullup bypasses both
   assign pullup_on = (global_pullup_enable & pue_bit & is_input) | force_pullup;

endmodule : pdp_pin_cell

// ### design/pdp_port_ctrl.sv
/*
 direction and weak pull-up control of a six-pin general-purpose port, with an avalon-mm register slave.
 assumes the oscillator mode and master-clear configuration are static straps synchronous to SYS_CLK.
*/
// The register addresses and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`include "pdp_regs.svh"

// Contract
// - direction bit one makes the pin a tri-stated input, zero drives it.
// - bits seven and six of both registers read zero.
// - direction bit three always reads one; pin three is input only.
// - in crystal modes direction bits five and four read one.
// - each pull-up enable bit switches its pin's weak pull-up.
// - a pin set as output has its weak pull-up switched off.
// - pull-ups other than the master-clear one need the global enable, which is off after reset.
// - master-clear configuration forces pin three's weak pull-up on.
// - in crystal modes pull-up bits five and four read one.
module pdp_port_ctrl #(
   parameter int PINS = 6
) (
   // clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RSTN,
   // avalon-mm slave
   input  wire logic [3:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   output logic      [1:0]  AVS_RESPONSE,
   // configuration straps
   input  wire logic [2:0]  OSC_MODE,
   input  wire logic        EXTERNAL_MASTER_CLEAR_MODE,
   // pin control
   output logic [PINS-1:0]  PIN_OE,
   output logic [PINS-1:0]  PIN_PULLUP
);

   // ----------------------------------------------------------------
   // stored state
   // ----------------------------------------------------------------
   logic [5:0]        port_direction_bits;
   logic [5:0]        pullup_enable_bits;
   logic              global_pullup_enable;
   pdp_pkg::pdp_bus_e bus_state;
   logic              crystal_mode;
   logic [5:0]        dir_view;
   logic [5:0]        pue_view;
   logic [PINS-1:0]   next_oe;
   logic [PINS-1:0]   next_pu;
   logic [31:0]       next_rdata;
   logic              unmapped;
   logic              wr_take;
   pdp_pkg::pdp_pins_s view;

   assign crystal_mode = (OSC_MODE == `PDP_OSC_LP) | (OSC_MODE == `PDP_OSC_XT) | (OSC_MODE == `PDP_OSC_HS);

   // ----------------------------------------------------------------
   // readback views
   // ----------------------------------------------------------------
   always_comb begin
      dir_view = port_direction_bits;
      pue_view = pullup_enable_bits;
      dir_view[`PDP_PIN3] = 1'b1;
      if (crystal_mode) begin
         dir_view[`PDP_XTAL_HI:`PDP_XTAL_LO] = 2'h3;
      end
      if (crystal_mode) begin
         pue_view[`PDP_XTAL_HI:`PDP_XTAL_LO] = 2'h3;
      end
   end

   assign view.dir = dir_view;
   assign view.pue = pue_view;

   // ----------------------------------------------------------------
   // bus slave: one wait cycle, then answer
   // ----------------------------------------------------------------
   assign wr_take  = AVS_WRITE & (bus_state == pdp_pkg::PDP_ANSWER);
   assign unmapped = (AVS_ADDRESS != `PDP_OFS_DIR) & (AVS_ADDRESS != `PDP_OFS_PUE)
                   & (AVS_ADDRESS != `PDP_OFS_CTRL) & (AVS_ADDRESS != `PDP_OFS_STAT);

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         bus_state <= pdp_pkg::PDP_IDLE;
      end else begin
         case (bus_state)
            pdp_pkg::PDP_IDLE: begin
               if (AVS_READ | AVS_WRITE) begin
                  bus_state <= pdp_pkg::PDP_ANSWER;
               end
            end
            default: begin
               bus_state <= pdp_pkg::PDP_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         AVS_WAITREQUEST <= 1'b1;
      end else begin
         AVS_WAITREQUEST <= ~((bus_state == pdp_pkg::PDP_IDLE) & (AVS_READ | AVS_WRITE));
      end
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (AVS_ADDRESS == `PDP_OFS_DIR) begin
         next_rdata[5:0] = view.dir;
      end else if (AVS_ADDRESS == `PDP_OFS_PUE) begin
         next_rdata[5:0] = view.pue;
      end else if (AVS_ADDRESS == `PDP_OFS_CTRL) begin
         next_rdata[`PDP_CTRL_GPU] = global_pullup_enable;
      end else if (AVS_ADDRESS == `PDP_OFS_STAT) begin
         next_rdata[PINS-1:0]           = PIN_PULLUP;
         next_rdata[8+PINS-1:8]         = PIN_OE;
         next_rdata[16]                 = crystal_mode;
         next_rdata[17]                 = EXTERNAL_MASTER_CLEAR_MODE;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         AVS_READDATA <= 32'h0000_0000;
         AVS_RESPONSE <= 2'h0;
      end else if ((bus_state == pdp_pkg::PDP_IDLE) & (AVS_READ | AVS_WRITE)) begin
         AVS_READDATA <= AVS_READ ? next_rdata : 32'h0000_0000;
         AVS_RESPONSE <= unmapped ? 2'h2 : 2'h0;
      end
   end

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   // direction storage, reset to all inputs
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         port_direction_bits <= `PDP_DIR_RST;
      end else if (wr_take & AVS_BYTEENABLE[0] & (AVS_ADDRESS == `PDP_OFS_DIR)) begin
         port_direction_bits <= AVS_WRITEDATA[5:0];
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         pullup_enable_bits <= `PDP_PUE_RST;
      end else if (wr_take & AVS_BYTEENABLE[0] & (AVS_ADDRESS == `PDP_OFS_PUE)) begin
         pullup_enable_bits <= AVS_WRITEDATA[5:0];
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         global_pullup_enable <= `PDP_GPU_RST;
      end else if (wr_take & AVS_BYTEENABLE[0] & (AVS_ADDRESS == `PDP_OFS_CTRL)) begin
         global_pullup_enable <= AVS_WRITEDATA[`PDP_CTRL_GPU];
      end
   end

   // ----------------------------------------------------------------
   // per-pin control
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < PINS; g++) begin : g_pin
         logic f_in;
         logic f_pu;
         // forced bits override stored values for the pins
         assign f_in = (g == `PDP_PIN3) | (crystal_mode & ((g == `PDP_XTAL_LO) | (g == `PDP_XTAL_HI)));
         // master clear forces pin three pull-up
         assign f_pu = (g == `PDP_PIN3) & EXTERNAL_MASTER_CLEAR_MODE;
         pdp_pin_cell u_cell (
            .dir_bit              (port_direction_bits[g]),
            .pue_bit              (pullup_enable_bits[g]),
            .global_pullup_enable (global_pullup_enable),
            .force_input          (f_in),
            .force_pullup         (f_pu),
            .out_en               (next_oe[g]),
            .pullup_on            (next_pu[g])
         );
      end
   endgenerate

   // registered pin outputs: one cycle behind the stored state
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         PIN_OE     <= '0;
         PIN_PULLUP <= '0;
      end else begin
         PIN_OE     <= next_oe;
         PIN_PULLUP <= next_pu;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_pin3_never_out: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      !PIN_OE[`PDP_PIN3]) else $error("pin three driven");

   a_dir_drives: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      PIN_OE[0] == !$past(port_direction_bits[0])) else $error("pin zero enable wrong");

   a_upper_zero: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (!AVS_WAITREQUEST && $past(AVS_READ) && ($past(AVS_ADDRESS) == `PDP_OFS_DIR
       || $past(AVS_ADDRESS) == `PDP_OFS_PUE)) |-> (AVS_READDATA[31:6] == 26'h0)) else $error("upper bits set");

   a_dir3_reads_one: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (!AVS_WAITREQUEST && $past(AVS_READ) && $past(AVS_ADDRESS) == `PDP_OFS_DIR) |->
      AVS_READDATA[`PDP_PIN3]) else $error("direction bit three reads zero");

   a_xtal_dir_one: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (!AVS_WAITREQUEST && $past(AVS_READ) && $past(AVS_ADDRESS) == `PDP_OFS_DIR && $past(crystal_mode)) |->
      (AVS_READDATA[5:4] == 2'h3)) else $error("crystal direction bits not one");

   a_pullup_off_out: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      PIN_OE[0] |-> !PIN_PULLUP[0]) else $error("pull-up on driven pin");

   a_global_gate: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (!$past(global_pullup_enable) && !$past(EXTERNAL_MASTER_CLEAR_MODE)) |-> (PIN_PULLUP == '0)) else $error("pull-up without global");

   a_pullup_follow: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      ($past(global_pullup_enable) && $past(port_direction_bits[1])) |->
      (PIN_PULLUP[1] == $past(pullup_enable_bits[1]))) else $error("pull-up one mismatch");

   a_external_master_clear_pullup: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      ($past(EXTERNAL_MASTER_CLEAR_MODE) && $past(RSTN)) |-> PIN_PULLUP[`PDP_PIN3]) else $error("master clear pull-up missing");

   a_xtal_pue_one: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (!AVS_WAITREQUEST && $past(AVS_READ) && $past(AVS_ADDRESS) == `PDP_OFS_PUE && $past(crystal_mode)) |->
      (AVS_READDATA[5:4] == 2'h3)) else $error("crystal pull-up bits not one");

   a_xtal_pins_in: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      $past(crystal_mode) |-> (PIN_OE[5:4] == 2'h0)) else $error("crystal pin driven");

endmodule : pdp_port_ctrl

// ### dv/pdp_pin_model.sv
/*
 pin-side model of the circuitry hung on the six port pins.
 assumes the block's output enables and pull-up controls arrive registered on clk.
*/
`timescale 1ns/1ps

module pdp_pin_model (
   // clock
   input  wire logic       clk,
   // pin control from the block
   input  wire logic [5:0] oe,
   input  wire logic [5:0] pullup_on,
   input  wire logic [5:0] drive,
   // resolved pin level
   output logic      [5:0] level
);
   logic [5:0] churn = 6'h15;

   // a floating pin toggles each cycle so an unknown never passes for a lucky value
   always @(posedge clk) churn <= ~churn;

   always_comb
      for (int i = 0; i < 6; i++)
         level[i] = oe[i] ? drive[i] : (pullup_on[i] ? 1'b1 : churn[i]);
endmodule : pdp_pin_model

// ### dv/tb_port_direction_pullup_ctrl.sv
/*
 self-checking bench for pdp_port_ctrl against an integer model of the port registers.
 assumes the avalon-mm slave answers on its own time; straps change only between transfers.
*/
`timescale 1ns/1ps
`include "pdp_regs.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value %s expected %h seen %h", n, e, g); end end

module tb_port_direction_pullup_ctrl;
   logic        sys_clk = 0, rstn = 0, rd = 0, wr = 0, external_master_clear = 0, wait_r;
   logic [3:0]  addr = 0, be = 0;
   logic [31:0] wdata = 0, rdata, rdata_q;
   logic [1:0]  resp, resp_q;
   logic [2:0]  osc = 3'h7;
   logic [5:0]  oe, pu, level, drive = 0;
   logic [3:0]  tbl [5] = '{`PDP_OFS_DIR, `PDP_OFS_PUE, `PDP_OFS_CTRL, `PDP_OFS_STAT, 4'h2};
   integer      seed = 32'h80b0d934, mismatches = 0, tests_run = 0, m_dir, m_pue, m_gpu;

   pdp_port_ctrl #(.PINS(6)) dut_u (.SYS_CLK(sys_clk), .RSTN(rstn), .AVS_ADDRESS(addr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(wait_r), .AVS_RESPONSE(resp), .OSC_MODE(osc), .EXTERNAL_MASTER_CLEAR_MODE(external_master_clear),
      .PIN_OE(oe), .PIN_PULLUP(pu));
   pdp_pin_model pins_u (.clk(sys_clk), .oe(oe), .pullup_on(pu), .drive(drive), .level(level));

   always #5 sys_clk = ~sys_clk;

   // ------------------------------------------------------------
   // reference model
   // ------------------------------------------------------------
   function automatic logic [31:0] exp_reg(input logic [3:0] a);
      logic [5:0] x, d, p;
      x = (osc < 3'h3) ? 6'h30 : 6'h00;
      d = 6'(m_dir) | 6'h08 | x;
      p = ((m_gpu != 0) ? (6'(m_pue) & d) : 6'h00) | (external_master_clear ? 6'h08 : 6'h00);
      case (a)
         `PDP_OFS_DIR: exp_reg = {26'h0, d};
         `PDP_OFS_PUE: exp_reg = {26'h0, 6'(m_pue) | x};
         `PDP_OFS_CTRL: exp_reg = {31'h0, m_gpu[0]};
         `PDP_OFS_STAT: exp_reg = {14'h0, external_master_clear, x[4], 2'h0, ~d, 2'h0, p};
         default: exp_reg = 32'h0;
      endcase
   endfunction : exp_reg

   // ------------------------------------------------------------
   // bus and checks
   // ------------------------------------------------------------
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
      @(posedge sys_clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= d;
      be <= b;
      do @(posedge sys_clk); while (wait_r !== 1'b0);
      rdata_q = rdata;
      resp_q = resp;
      rd <= 1'b0;
      wr <= 1'b0;
      if (w && b[0] && a == `PDP_OFS_DIR) m_dir = d[5:0];
      if (w && b[0] && a == `PDP_OFS_PUE) m_pue = d[5:0];
      if (w && b[0] && a == `PDP_OFS_CTRL) m_gpu = d[0];
   endtask : bus

   task automatic check_all;
      logic [31:0] e;
      for (int i = 0; i < 5; i++) begin
         bus(1'b0, tbl[i], 32'h0, 4'h0);
         `CHK("readback", exp_reg(tbl[i]), rdata_q)
         `CHK("response", {30'h0, (i == 4) ? 2'h2 : 2'h0}, {30'h0, resp_q})
      end
      e = exp_reg(`PDP_OFS_STAT);
      `CHK("pin control", {20'h0, e[13:8], e[5:0]}, {20'h0, oe, pu})
      `CHK("pin level", {26'h0, (e[13:8] & drive) | (e[5:0] & ~e[13:8])}, {26'h0, level & (oe | pu)})
   endtask : check_all

   task automatic do_reset;
      rstn <= 1'b0;
      repeat (5) @(posedge sys_clk);
      `CHK("pins in reset", 32'h0, {20'h0, oe, pu})
      rstn <= 1'b1;
      m_dir = 63;
      m_pue = 63;
      m_gpu = 0;
   endtask : do_reset

   task automatic close_out;
      if (mismatches == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : close_out

   // ------------------------------------------------------------
   // stimulus
   // ------------------------------------------------------------
   initial begin
      do_reset;
      check_all;
      for (int k = 0; k < 80; k++) begin
         // straps move only between transfers, since the design treats them as static
         if (k % 4 == 0) begin
            osc <= 3'($random(seed));
            external_master_clear <= 1'($random(seed));
            drive <= 6'($random(seed));
         end
         if (k == 40) do_reset;
         bus(1'b1, tbl[$unsigned($random(seed)) % 5], $random(seed), 4'($random(seed)) | {3'h0, k % 3 != 0});
         check_all;
      end
      close_out;
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      close_out;
   end
endmodule : tb_port_direction_pullup_ctrl
